// ===== inc/wdp_pkg.sv
// ---------------------------------------------------------------------------
// Purpose : Shared constants and types of the watchdog timer with prescaler
// Assumes : 50 MHz system clock; the watchdog oscillator is modelled by a
//           free-running divider of that clock that no sleep state gates
// Notes   : Register map is word aligned on an Avalon-MM slave
// ---------------------------------------------------------------------------
// Operation
// [RL1] Counter runs on free oscillator, also asleep
// [RL2] Timeout while running requests full device reset
// [RL3] Timeout while asleep wakes, no reset
// [RL4] Cleared enable fuse disables watchdog completely
// [RL5] Unprescaled timeout is nominally 18 ms
// [RL6] Software assigns prescaler up to 1:128
// [RL7] Clear or sleep instruction clears counter, prescaler
// [RL8] Timeout clears the active-low timeout flag
// [RL9] Oscillator rate and length are parameters
// [RL10] After timeout counter and prescaler restart
package wdp_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ     = 50_000_000;             // System clock rate
  localparam int OSC_HZ     = 32_000;                 // Nominal watchdog oscillator
  localparam int TIMEOUT_MS = 18;                     // Unprescaled timeout, ms
  localparam int OSC_DIV    = CLK_HZ / OSC_HZ;        // Clock cycles per oscillator tick
  localparam int WDT_TICKS  = (OSC_HZ * TIMEOUT_MS) / 1000; // Ticks per timeout
  localparam int PS_W       = 3;                      // Prescaler select width
  localparam int PS_CNT_W   = 7;                      // Prescaler counter, up to 1:128

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_OPTION = 8'h00;          // Prescaler assignment and ratio
  localparam logic [7:0] OFS_STATUS = 8'h04;          // Timeout flag, sleep, fuse
  localparam logic [7:0] OFS_EVENT  = 8'h08;          // Sticky events, read clears
  localparam logic [7:0] OFS_MASK   = 8'h0C;          // Interrupt mask
  localparam logic [7:0] OFS_COUNT  = 8'h10;          // Live counter value

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int OPT_ASSIGN_BIT = 0;                  // 1 = prescaler feeds watchdog
  localparam int OPT_PS_LSB     = 1;                  // Ratio select, 1:2^n
  localparam int STAT_TO_BIT    = 0;                  // Timeout flag, active low
  localparam int STAT_SLEEP_BIT = 1;                  // Device asleep
  localparam int STAT_FUSE_BIT  = 2;                  // Enable fuse level
  localparam int EVT_RST_BIT    = 0;                  // Timeout reset event
  localparam int EVT_WAKE_BIT   = 1;                  // Timeout wake event
  localparam int EVT_W          = 2;                  // Event register width

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0]       OPTION_RST = 4'h0;     // Prescaler not assigned
  localparam logic [EVT_W-1:0] MASK_RST   = 2'h0;     // All events masked
  localparam logic [EVT_W-1:0] EVT_RST    = 2'h0;     // No events pending

  // ---------------------------------------------------------------------------
  // Operating state
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,                                  // Normal execution
    ST_SLEEP = 3'h2,                                  // Core clock stopped
    ST_OFF   = 3'h4                                   // Fuse disables watchdog
  } wdp_state_t;

endpackage

// ===== verilog/wdp_watchdog.sv
// ---------------------------------------------------------------------------
// Purpose : Watchdog timer with optional prescaler, reset and wake-up outputs
// Assumes : All inputs but rst synchronous to clk; instruction strobes are one cycle
// Notes   : Registers on Avalon-MM, one level interrupt from sticky events
// ---------------------------------------------------------------------------
`timescale 1ns/1ps

module wdp_watchdog #(
  parameter int OSC_DIV   = wdp_pkg::OSC_DIV,         // Clock cycles per oscillator tick
  parameter int WDT_TICKS = wdp_pkg::WDT_TICKS,       // Oscillator ticks per timeout
  parameter int CNT_W     = 16                        // Watchdog counter width
) (
  input  wire logic        clk,                        // System clock, 50 MHz
  input  wire logic        rst,                        // Asynchronous reset, high
  input  wire logic [7:0]  avs_address,                // Byte address
  input  wire logic        avs_read,                   // Read request
  input  wire logic        avs_write,                  // Write request
  input  wire logic [31:0] avs_writedata,              // Write data
  input  wire logic [3:0]  avs_byteenable,             // Byte lanes
  output logic      [31:0] avs_readdata,               // Read data
  output logic             avs_waitrequest,            // Stall until answer
  input  wire logic        watchdog_enable_fuse,       // Configuration fuse level
  input  wire logic        clear_watchdog_instruction, // Clear strobe from core
  input  wire logic        sleep_instruction,          // Sleep strobe from core
  input  wire logic        other_wake,                 // Non-watchdog wake source
  output logic             device_reset_req,           // Full device reset pulse
  output logic             wake_req,                   // Wake-from-sleep pulse
  output logic             timeout_flag_n,             // Cleared by a timeout
  output logic             irq                         // Level interrupt
);

  // ---------------------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------------------
  localparam logic [15:0]      DIV_LAST = 16'(OSC_DIV - 1);     // Divider wrap value
  localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_TICKS - 1); // Terminal count

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [15:0]                    div_cnt_reg;   // Oscillator divider
  logic [15:0]                    div_cnt_next;  // Divider next value
  logic [wdp_pkg::PS_CNT_W-1:0]   ps_cnt_reg;    // Prescaler counter
  logic [wdp_pkg::PS_CNT_W-1:0]   ps_cnt_next;   // Prescaler next value
  logic [CNT_W-1:0]               wdt_cnt_reg;   // Watchdog counter
  logic [CNT_W-1:0]               wdt_cnt_next;  // Watchdog next value
  logic                           assign_reg;    // Prescaler assigned
  logic [wdp_pkg::PS_W-1:0]       ps_sel_reg;    // Ratio select
  logic [wdp_pkg::EVT_W-1:0]      evt_reg;       // Sticky events
  logic [wdp_pkg::EVT_W-1:0]      evt_next;      // Events next value
  logic [wdp_pkg::EVT_W-1:0]      mask_reg;      // Interrupt mask
  logic                           to_flag_reg;   // Timeout flag, low after timeout
  logic                           to_flag_next;  // Flag next value
  logic                           rst_req_reg;   // Reset pulse
  logic                           wake_req_reg;  // Wake pulse
  logic                           ack_reg;       // Bus answer cycle
  logic [31:0]                    rdata_reg;     // Read data register
  wdp_pkg::wdp_state_t            state_reg;     // Operating state
  wdp_pkg::wdp_state_t            state_next;    // State next value

  // ---------------------------------------------------------------------------
  // Oscillator and counting
  // ---------------------------------------------------------------------------
  wire        osc_tick   = (div_cnt_reg == DIV_LAST);           // One-cycle tick
  wire [7:0]  ratio_full = 8'h01 << ps_sel_reg;                 // Ratio 1..128
  wire [wdp_pkg::PS_CNT_W-1:0] ratio_mask = 7'(ratio_full - 8'h01); // Last prescale value
  wire        ps_done    = assign_reg ? (ps_cnt_reg == ratio_mask) : 1'b1; // Prescale wrap
  // [RL7] Clear and sleep strobes
  wire        clr_cmd    = clear_watchdog_instruction | sleep_instruction; // Clear strobes
  wire        cnt_step   = watchdog_enable_fuse & osc_tick & ps_done;    // Counter advance
  // [RL9] Parameterised terminal count
  wire        at_last    = (wdt_cnt_reg == WDT_LAST);           // One counter step from timeout
  // [RL5] Timeout at terminal count
  wire        timeout_hit = cnt_step & at_last & ~clr_cmd;      // Clear defeats timeout
  wire        restart    = ~watchdog_enable_fuse | clr_cmd | timeout_hit; // Zero both counters
  wire        asleep     = (state_reg == wdp_pkg::ST_SLEEP);    // Sleep state

  // [RL1] Free divider never gated
  assign div_cnt_next = osc_tick ? 16'h0000 : div_cnt_reg + 16'h0001;

  // [RL6] Prescaler divides oscillator ticks
  assign ps_cnt_next = restart ? '0 :
                       (osc_tick & assign_reg) ? (ps_done ? '0 : ps_cnt_reg + 7'h01) :
                       assign_reg ? ps_cnt_reg : '0;

  // [RL10] Restart from zero
  assign wdt_cnt_next = restart ? '0 : cnt_step ? wdt_cnt_reg + CNT_W'(1) : wdt_cnt_reg;

  // Divider, prescaler and counter registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 16'h0000;
      ps_cnt_reg  <= '0;
      wdt_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      ps_cnt_reg  <= ps_cnt_next;
      wdt_cnt_reg <= wdt_cnt_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Operating state
  // ---------------------------------------------------------------------------
  // Sleep tracking decides whether a timeout resets or wakes
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wdp_pkg::ST_RUN: begin
        // [RL4] Fuse clear disables
        if (!watchdog_enable_fuse) begin
          state_next = wdp_pkg::ST_OFF;
        end else if (sleep_instruction) begin
          state_next = wdp_pkg::ST_SLEEP;
        end
      end
      wdp_pkg::ST_SLEEP: begin
        if (!watchdog_enable_fuse) begin
          state_next = wdp_pkg::ST_OFF;
        end else if (timeout_hit || other_wake) begin
          state_next = wdp_pkg::ST_RUN;         // Resume normal execution
        end
      end
      wdp_pkg::ST_OFF: begin
        if (watchdog_enable_fuse) begin
          state_next = wdp_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = wdp_pkg::ST_RUN;           // Recover from illegal code
      end
    endcase
  end

  // Timeout flag: a clear/sleep strobe defeats a timeout in the same cycle, so the set wins
  // [RL8] Timeout clears flag
  assign to_flag_next = timeout_hit ? 1'b0 :
                        (clr_cmd & watchdog_enable_fuse) ? 1'b1 : to_flag_reg;

  // State, flag and output pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg    <= wdp_pkg::ST_RUN;
      to_flag_reg  <= 1'b1;
      rst_req_reg  <= 1'b0;
      wake_req_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      to_flag_reg  <= to_flag_next;
      // [RL2] Reset when running
      rst_req_reg  <= timeout_hit & ~asleep;
      // [RL3] Wake when asleep
      wake_req_reg <= timeout_hit & asleep;
    end
  end

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  // One wait cycle: first edge captures data, second edge completes
  wire req      = avs_read | avs_write;                         // Request present
  wire accept   = req & ack_reg;                                // Completing edge
  wire wr_acc   = accept & avs_write & avs_byteenable[0];       // Effective write, lane 0
  wire rd_evt   = accept & avs_read & (avs_address == wdp_pkg::OFS_EVENT); // Read clears
  wire sel_opt  = (avs_address == wdp_pkg::OFS_OPTION);         // Option select
  wire sel_mask = (avs_address == wdp_pkg::OFS_MASK);           // Mask select
  wire [wdp_pkg::EVT_W-1:0] evt_set = {wake_req_reg, rst_req_reg}; // New events
  wire [31:0] rd_opt  = {28'h000_0000, ps_sel_reg, assign_reg};  // Option word
  wire [31:0] rd_stat = {29'h0000_0000, watchdog_enable_fuse, asleep, to_flag_reg}; // Status
  wire [31:0] rd_evtw = {30'h0000_0000, evt_reg};                // Events word
  wire [31:0] rd_mask = {30'h0000_0000, mask_reg};               // Mask word
  wire [31:0] rd_cnt  = 32'(wdt_cnt_reg);                        // Counter word
  // Unmapped addresses read zero
  wire [31:0] rd_mux  = (avs_address == wdp_pkg::OFS_OPTION) ? rd_opt  :
                        (avs_address == wdp_pkg::OFS_STATUS) ? rd_stat :
                        (avs_address == wdp_pkg::OFS_EVENT)  ? rd_evtw :
                        (avs_address == wdp_pkg::OFS_MASK)   ? rd_mask :
                        (avs_address == wdp_pkg::OFS_COUNT)  ? rd_cnt  : 32'h0000_0000;

  // Read clears only the bits captured into the read word, so an event that lands
  // during the wait cycle is not lost; a new event in the clear cycle survives too
  assign evt_next = (evt_reg & ~(rd_evt ? rdata_reg[wdp_pkg::EVT_W-1:0] : {wdp_pkg::EVT_W{1'b0}})) | evt_set;

  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // Bus handshake and read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg & avs_read) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Software registers and sticky events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      assign_reg <= wdp_pkg::OPTION_RST[wdp_pkg::OPT_ASSIGN_BIT];
      ps_sel_reg <= wdp_pkg::OPTION_RST[wdp_pkg::OPT_PS_LSB +: wdp_pkg::PS_W];
      mask_reg   <= wdp_pkg::MASK_RST;
      evt_reg    <= wdp_pkg::EVT_RST;
    end else begin
      evt_reg <= evt_next;
      // [RL6] Option register write
      if (wr_acc && sel_opt) begin
        assign_reg <= avs_writedata[wdp_pkg::OPT_ASSIGN_BIT];
        ps_sel_reg <= avs_writedata[wdp_pkg::OPT_PS_LSB +: wdp_pkg::PS_W];
      end
      if (wr_acc && sel_mask) begin
        mask_reg <= avs_writedata[wdp_pkg::EVT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign device_reset_req = rst_req_reg;
  assign wake_req         = wake_req_reg;
  assign timeout_flag_n   = to_flag_reg;
  assign irq              = |(evt_reg & mask_reg);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_OSC_FREE: assert property (@(posedge clk) disable iff (rst) // [RL1]
    osc_tick |=> !osc_tick [*2])
    else $error("oscillator tick repeated too early");

  AST_RUN_RESET: assert property (@(posedge clk) disable iff (rst) // [RL2]
    (timeout_hit && state_reg == wdp_pkg::ST_RUN) |=> (device_reset_req && !wake_req))
    else $error("running timeout did not request reset");

  AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (rst) // [RL3]
    (timeout_hit && asleep) |=> (wake_req && !device_reset_req && state_reg == wdp_pkg::ST_RUN))
    else $error("sleeping timeout did not wake");

  AST_FUSE_OFF: assert property (@(posedge clk) disable iff (rst) // [RL4]
    !watchdog_enable_fuse |=> (!device_reset_req && !wake_req && wdt_cnt_reg == '0))
    else $error("disabled watchdog still active");

  AST_TERMINAL: assert property (@(posedge clk) disable iff (rst) // [RL5]
    (cnt_step && wdt_cnt_reg == WDT_LAST && !clr_cmd) |=> (wdt_cnt_reg == '0 && !timeout_flag_n))
    else $error("terminal count did not time out");

  AST_PRESCALE: assert property (@(posedge clk) disable iff (rst) // [RL6]
    (cnt_step && assign_reg) |-> (ps_cnt_reg == ratio_mask && osc_tick))
    else $error("counter stepped before prescaler wrap");

  AST_CLEAR: assert property (@(posedge clk) disable iff (rst) // [RL7]
    clr_cmd |=> (wdt_cnt_reg == '0 && ps_cnt_reg == '0 && !device_reset_req && !wake_req))
    else $error("clear strobe did not clear counters");

  AST_FLAG: assert property (@(posedge clk) disable iff (rst) // [RL8]
    timeout_hit |=> (!timeout_flag_n && $past(timeout_flag_n) == to_flag_reg || !timeout_flag_n))
    else $error("timeout flag not cleared");

  AST_RESTART: assert property (@(posedge clk) disable iff (rst) // [RL10]
    timeout_hit |=> (wdt_cnt_reg == '0 && ps_cnt_reg == '0) ##1 (wdt_cnt_reg <= CNT_W'(1)))
    else $error("counters did not restart after timeout");

  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (rst)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule

// ===== sim/wdp_core_model.sv
// ---------------------------------------------------------------------------
// Purpose : Stand-in for the core and the reset and sleep control
// Assumes : Bench commands are one-cycle pulses on clk
// Notes   : Counts the watchdog's reset and wake pulses for the bench
// ---------------------------------------------------------------------------
`timescale 1ns/1ps

module wdp_core_model (
  input  wire logic clk,                        // System clock
  input  wire logic rst,                        // Asynchronous reset, high
  input  wire logic cmd_clear,                  // Bench asks for a clear
  input  wire logic cmd_sleep,                  // Bench asks for a sleep
  input  wire logic cmd_wake,                   // Bench asks for an outside wake
  input  wire logic device_reset_req,           // Reset request from watchdog
  input  wire logic wake_req,                   // Wake request from watchdog
  output logic      clear_watchdog_instruction, // Clear strobe
  output logic      sleep_instruction,          // Sleep strobe
  output logic      other_wake,                 // Outside wake pulse
  output int        reset_count,                // Reset pulses seen
  output int        wake_count                  // Wake pulses seen
);
  logic asleep_reg; // Core halted in sleep

  // Strobes leave on a clock edge; a halted core runs no instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clear_watchdog_instruction <= 1'b0;
      sleep_instruction          <= 1'b0;
      other_wake                 <= 1'b0;
      reset_count                <= 0;
      wake_count                 <= 0;
      asleep_reg                 <= 1'b0;
    end else begin
      clear_watchdog_instruction <= cmd_clear & ~asleep_reg;
      sleep_instruction          <= cmd_sleep & ~asleep_reg;
      other_wake                 <= cmd_wake;
      reset_count                <= reset_count + int'(device_reset_req);
      wake_count                 <= wake_count + int'(wake_req);
      if (sleep_instruction) begin
        asleep_reg <= 1'b1;
      end else if (wake_req | other_wake | device_reset_req) begin
        asleep_reg <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/testbench.sv
// ---------------------------------------------------------------------------
// Purpose : Self-checking bench of the watchdog timer with prescaler
// Assumes : Short divider and timeout parameters keep the run brief
// Notes   : Timeouts are checked as windows, the oscillator phase is free
// ---------------------------------------------------------------------------
`timescale 1ns/1ps

module testbench;
  localparam int D     = 4;     // Clock cycles per oscillator tick
  localparam int T     = 4;     // Ticks per unprescaled timeout
  localparam int LIMIT = 30000; // Cycle ceiling against a hang
  logic        clk = 1'b0;      // 50 MHz clock
  logic        rst;             // Reset, high
  logic [7:0]  avs_address;     // Bus address
  logic        avs_read;        // Bus read
  logic        avs_write;       // Bus write
  logic [31:0] avs_writedata;   // Bus write data
  logic [3:0]  avs_byteenable;  // Bus lanes
  logic [31:0] avs_readdata;    // Bus read data
  logic        avs_waitrequest; // Bus stall
  logic        fuse;            // Enable fuse level
  logic        cmd_clear;       // Ask core for a clear
  logic        cmd_sleep;       // Ask core for a sleep
  logic        cmd_wake;        // Ask core for an outside wake
  logic        clr_s;           // Clear strobe
  logic        slp_s;           // Sleep strobe
  logic        owk_s;           // Outside wake
  logic        rst_req;         // Reset request
  logic        wk_req;          // Wake request
  logic        flag_n;          // Timeout flag, low after a timeout
  logic        irq;             // Level interrupt
  int          reset_count;     // Reset pulses counted by the core
  int          wake_count;      // Wake pulses counted by the core
  int          fails;           // Mismatches
  int          check_count;     // Comparisons made
  int          cyc;             // Cycles run
  int          seed;            // Random seed
  int          r0;              // Reset count at a window start
  logic [31:0] q;               // Last read data

  wdp_watchdog #(.OSC_DIV(D), .WDT_TICKS(T)) wdp_watchdog_i (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .watchdog_enable_fuse(fuse), .clear_watchdog_instruction(clr_s),
    .sleep_instruction(slp_s), .other_wake(owk_s), .device_reset_req(rst_req), .wake_req(wk_req),
    .timeout_flag_n(flag_n), .irq(irq));
  wdp_core_model wdp_core_model_i (
    .clk(clk), .rst(rst), .cmd_clear(cmd_clear), .cmd_sleep(cmd_sleep), .cmd_wake(cmd_wake),
    .device_reset_req(rst_req), .wake_req(wk_req), .clear_watchdog_instruction(clr_s),
    .sleep_instruction(slp_s), .other_wake(owk_s), .reset_count(reset_count), .wake_count(wake_count));

  // Free-running clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk_time(input int lo, input int hi, input int c);
    check_count++;
    if (c < lo || c > hi) begin
      fails++;
      $display("BAD timeout cycles expected %0d..%0d seen %0d", lo, hi, c);
    end
  endtask

  // One bus transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    chk("bus answer", 1, n < 20);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(n, e, q);
  endtask

  // Core command: 0 clear, 1 sleep, 2 outside wake
  task automatic go(input int w);
    @(posedge clk);
    cmd_clear <= (w == 0);
    cmd_sleep <= (w == 1);
    cmd_wake  <= (w == 2);
    @(posedge clk);
    cmd_clear <= 1'b0;
    cmd_sleep <= 1'b0;
    cmd_wake  <= 1'b0;
  endtask

  // Wait for a timeout of n ticks; kind 0 reset, 1 wake
  task automatic expect_to(input int kind, input int n);
    int c;
    int w0;
    c  = 0;
    r0 = reset_count;
    w0 = wake_count;
    while (reset_count == r0 && wake_count == w0 && c < n * D + 20) begin
      @(posedge clk);
      c++;
    end
    chk_time((n - 1) * D - 3, n * D + 6, c);
    chk("reset pulses", (kind == 0), reset_count - r0);
    chk("wake pulses", (kind == 1), wake_count - w0);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1; avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0; fuse = 1'b0; cmd_clear = 1'b0; cmd_sleep = 1'b0; cmd_wake = 1'b0;
    fails = 0; check_count = 0; cyc = 0; seed = 75249;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values and refused accesses, fuse held low
    rd(8'h00, 32'h0000_0000, "option");
    rd(8'h04, 32'h0000_0001, "status");
    rd(8'h08, 32'h0000_0000, "events");
    rd(8'h0C, 32'h0000_0000, "mask");
    bus(1'b1, 8'h00, 32'h0000_000F, 4'hE);
    bus(1'b1, 8'h14, 32'h0000_000F, 4'hF);
    rd(8'h00, 32'h0000_0000, "option lanes");
    rd(8'h14, 32'h0000_0000, "unmapped");
    rd(8'h10, 32'h0000_0000, "count off");
    chk("no reset when off", 0, reset_count);
    fuse <= 1'b1;
    r0 = reset_count;
    repeat (12) begin
      go(0);
      repeat (2 + {$random(seed)} % 4) @(posedge clk);
    end
    chk("reset while cleared", r0, reset_count);
    bus(1'b1, 8'h0C, 32'h0000_0003, 4'h1);
    go(1);
    expect_to(1, T);
    chk("flag after wake", 0, flag_n);
    go(0);
    chk("irq set", 1, irq);
    rd(8'h08, 32'h0000_0002, "wake event");
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    go(0);
    bus(1'b1, 8'h0C, 32'h0000_0001, 4'h1);
    go(1);
    expect_to(1, T);
    repeat (3) @(posedge clk);
    chk("irq masked", 0, irq);
    rd(8'h08, 32'h0000_0002, "masked event");
    go(1);
    go(2);
    rd(8'h04, 32'h0000_0005, "status woken");
    go(0);
    fuse <= 1'b0;
    r0 = reset_count + wake_count;
    repeat (5 * T * D) @(posedge clk);
    chk("pulses when off", r0, reset_count + wake_count);
    chk("flag when off", 1, flag_n);
    for (int k = 0; k < 9; k++) begin
      fuse <= 1'b0;
      bus(1'b1, 8'h00, ({$random(seed)} & 32'hFFFF_FFF0) | ((k < 8) ? (2 * k + 1) : 0), 4'h1);
      rd(8'h00, (k < 8) ? (2 * k + 1) : 0, "option");
      fuse <= 1'b1;
      go(0);
      expect_to(0, (k < 8) ? (T << k) : T);
      expect_to(0, (k < 8) ? (T << k) : T);
      chk("flag after reset", 0, flag_n);
      rd(8'h08, 32'h0000_0001, "reset event");
      rd(8'h08, 32'h0000_0000, "events cleared");
    end
    test_done();
  end
endmodule
